//--- verilog/cbl_pkg.sv
package cbl_pkg;
  // ----------------------------------------------------------------
  // Reset values and vectors
  // ----------------------------------------------------------------
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] NMI_ADDR = 16'h0066;
  localparam logic [15:0] IM1_ADDR = 16'h0038;
  localparam logic [7:0] RST_MASK = 8'h38;
  localparam logic [1:0] IM_0 = 2'h0;
  localparam logic [1:0] IM_1 = 2'h1;
  localparam logic [1:0] IM_2 = 2'h2;
  // ----------------------------------------------------------------
  // Machine cycle lengths in T states
  // ----------------------------------------------------------------
  localparam logic [2:0] FETCH_LEN = 3'h4;
  localparam logic [2:0] MEM_LEN = 3'h3;
  localparam logic [2:0] INTA_LEN = 3'h4;
  localparam logic [2:0] IDX_IDLE = 3'h5;
  localparam logic [2:0] IMM_IDLE = 3'h2;
  localparam logic [2:0] ED_IDLE = 3'h1;
  localparam logic [2:0] T_ADDR = 3'h1;
  localparam logic [2:0] T_STRB = 3'h2;
  localparam logic [2:0] T_REFRESH_STROBE_N = 3'h3;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_PFX_X = 8'hdd;
  localparam logic [7:0] OP_PFX_Y = 8'hfd;
  localparam logic [7:0] OP_PFX_E = 8'hed;
  localparam logic [7:0] OP_HALT = 8'h76;
  localparam logic [7:0] OP_LD_MI = 8'h36;
  localparam logic [7:0] OP_LDA_BC = 8'h0a;
  localparam logic [7:0] OP_LDA_DE = 8'h1a;
  localparam logic [7:0] OP_LDA_NN = 8'h3a;
  localparam logic [7:0] OP_STA_BC = 8'h02;
  localparam logic [7:0] OP_STA_DE = 8'h12;
  localparam logic [7:0] OP_STA_NN = 8'h32;
  localparam logic [7:0] OP_DI = 8'hf3;
  localparam logic [7:0] OP_EI = 8'hfb;
  localparam logic [7:0] ED_A_I = 8'h57;
  localparam logic [7:0] ED_A_R = 8'h5f;
  localparam logic [7:0] ED_I_A = 8'h47;
  localparam logic [7:0] ED_R_A = 8'h4f;
  localparam logic [7:0] ED_IM0 = 8'h46;
  localparam logic [7:0] ED_IM1 = 8'h56;
  localparam logic [7:0] ED_IM2 = 8'h5e;
  // ----------------------------------------------------------------
  // Register fields, flags, input synchroniser lanes
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_M = 3'h6;
  localparam logic [2:0] REG_F = 3'h6;
  localparam logic [2:0] REG_A = 3'h7;
  localparam int FLG_S = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_H = 4;
  localparam int FLG_PV = 2;
  localparam int FLG_N = 1;
  localparam int SY_WAIT = 0;
  localparam int SY_INT = 1;
  localparam int SY_NMI = 2;
  localparam int SY_HOLD = 3;
  localparam logic [3:0] SY_RST = 4'hf;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MC_FETCH, MC_READ, MC_WRITE, MC_IDLE, MC_INTA, MC_HOLD
  } cbl_mc_t;
  typedef enum logic [3:0] {
    PH_OP, PH_DISP, PH_IMM, PH_LO, PH_HI, PH_RD, PH_WR, PH_XI, PH_EDX,
    PH_INTA
  } cbl_ph_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] dout;
    logic addr_oe_n;
    logic data_oe_n;
    logic ctl_oe_n;
    logic memory_cycle_n;
    logic port_cycle_n;
    logic rd_n;
    logic wr_n;
    logic fetch_cycle_n;
    logic refresh_strobe_n;
    logic halt_n;
    logic bus_grant_n;
  } cbl_pins_t;
  localparam cbl_pins_t PINS_RST = '{addr: 16'h0000, dout: 8'h00,
                                     default: 1'b1};
endpackage

//--- verilog/cbl_core.sv
`timescale 1ns/1ps
// Contract
// - Drive 16-bit address for 64K memory and for I/O selection.
// - Bus hold taken at machine cycle end before NMI; float bus, strobes.
// - Grant goes low only after the bus floats; master drives during grant.
// - Data moves over an 8-bit bidirectional bus.
// - After HALT, halt low, keep refreshing fetches until an interrupt.
// - Maskable interrupt taken at instruction end only if enable latch set.
// - Port strobe with fetch strobe acknowledges an interrupt for a vector.
// - Fetch strobe with memory strobe during every opcode fetch.
// - Memory strobe only while address is valid for memory access.
// - NMI beats INT, ignores enable latch, restarts at 0066H.
// - Reset clears latch, PC, I, R, selects mode 0, floats, idles.
// - Refresh strobe with memory strobe; low seven address bits refresh.
// - Wait states inserted while wait input stays low.
// - Store strobe only while data bus holds valid write data.
// - LD r,(HL) is 01 r 110, 7 T; indexed DD/FD+d, 19 T.
// - LD (HL),r is 01 110 r, 7 T; indexed forms 19 T.
// - LD (HL),n is 36 n; indexed prefix,36,d,n four bytes, 19 T.
// - 0A, 1A load A via BC, DE; 3A from absolute address, 13 T.
// - 02, 12 store A via BC, DE; 32 to absolute address.
// - ED 57/5F load A from I/R, PV=latch, H,N clear; 47/4F back; 9 T.
module cbl_core (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_data,
  input wire logic i_wait_n,
  input wire logic i_int_n,
  input wire logic i_nmi_n,
  input wire logic i_bus_hold_request_n,
  output logic [15:0] o_addr,
  output logic o_addr_oe_n,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  output logic o_ctl_oe_n,
  output logic o_memory_cycle_n,
  output logic o_port_cycle_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_fetch_cycle_n,
  output logic o_refresh_strobe_n,
  output logic o_halt_n,
  output logic o_bus_grant_n
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] pair(input logic [7:0] h,
                                       input logic [7:0] l);
    pair = {h, l};
  endfunction

  function automatic logic [2:0] mc_len(input cbl_pkg::cbl_mc_t mc,
                                        input logic [2:0] ilen);
    if (mc == cbl_pkg::MC_FETCH) begin
      mc_len = cbl_pkg::FETCH_LEN;
    end else if (mc == cbl_pkg::MC_INTA) begin
      mc_len = cbl_pkg::INTA_LEN;
    end else if (mc == cbl_pkg::MC_IDLE) begin
      mc_len = ilen;
    end else begin
      mc_len = cbl_pkg::MEM_LEN;
    end
  endfunction

  function automatic logic [15:0] ea(input logic [1:0] pfx,
                                     input logic [15:0] hl,
                                     input logic [15:0] ix,
                                     input logic [15:0] iy,
                                     input logic [7:0] d);
    logic [15:0] base;
    base = (pfx == 2'h1) ? ix : iy;
    ea = (pfx == 2'h0) ? hl : base + {{8{d[7]}}, d};
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sy1_r, sy2_r, sy3_r, flt_r;
  logic [3:0] sy1_nxt, sy2_nxt, sy3_nxt, flt_nxt;

  always_comb begin
    sy1_nxt = {i_bus_hold_request_n, i_nmi_n, i_int_n, i_wait_n};
    sy2_nxt = sy1_r;
    sy3_nxt = sy2_r;
    flt_nxt = (~(sy2_r ^ sy3_r) & sy3_r) | ((sy2_r ^ sy3_r) & flt_r);
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sy1_r <= cbl_pkg::SY_RST;
      sy2_r <= cbl_pkg::SY_RST;
      sy3_r <= cbl_pkg::SY_RST;
      flt_r <= cbl_pkg::SY_RST;
    end else begin
      sy1_r <= sy1_nxt;
      sy2_r <= sy2_nxt;
      sy3_r <= sy3_nxt;
      flt_r <= flt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------
  cbl_pkg::cbl_mc_t mc_r, mc_nxt, res_r, res_nxt;
  cbl_pkg::cbl_ph_t ph_r, ph_nxt, aft_r, aft_nxt;
  cbl_pkg::cbl_pins_t pins_r, pins_nxt;
  logic [2:0] t_r, t_nxt, ilen_r, ilen_nxt;
  logic [1:0] pfx_r, pfx_nxt, im_r, im_nxt;
  logic ed_r, ed_nxt, iff_r, iff_nxt, halt_r, halt_nxt;
  logic npend_r, npend_nxt, nold_r, nold_nxt;
  logic [7:0] op_r, op_nxt, disp_r, disp_nxt, lo_r, lo_nxt;
  logic [7:0] din_r, din_nxt, wd_r, wd_nxt, i_r, i_nxt, rr_r, rr_nxt;
  logic [15:0] ma_r, ma_nxt, pc_r, pc_nxt, ix_r, iy_r;
  logic [7:0] rf_r [8];
  logic [7:0] rf_nxt [8];

  always_comb begin
    logic fin, stall, hold;
    logic [7:0] o, src;
    logic [15:0] hl;
    cbl_pkg::cbl_mc_t nmc;
    cbl_pkg::cbl_ph_t nph;
    fin = 1'b0;
    nmc = cbl_pkg::MC_FETCH;
    nph = cbl_pkg::PH_OP;
    o = din_r;
    src = i_r;
    hl = pair(rf_r[4], rf_r[5]);
    hold = ~flt_r[cbl_pkg::SY_HOLD];
    stall = (t_r == cbl_pkg::T_STRB) && !flt_r[cbl_pkg::SY_WAIT] &&
            (mc_r != cbl_pkg::MC_IDLE) && (mc_r != cbl_pkg::MC_HOLD);
    mc_nxt = mc_r; res_nxt = res_r; ph_nxt = ph_r; aft_nxt = aft_r;
    t_nxt = t_r; ilen_nxt = ilen_r; pfx_nxt = pfx_r; im_nxt = im_r;
    ed_nxt = ed_r; iff_nxt = iff_r; halt_nxt = halt_r;
    npend_nxt = npend_r; nold_nxt = flt_r[cbl_pkg::SY_NMI];
    op_nxt = op_r; disp_nxt = disp_r; lo_nxt = lo_r; din_nxt = din_r;
    wd_nxt = wd_r; i_nxt = i_r; rr_nxt = rr_r; ma_nxt = ma_r;
    pc_nxt = pc_r;
    for (int k = 0; k < 8; k++) begin
      rf_nxt[k] = rf_r[k];
    end
    if (mc_r == cbl_pkg::MC_HOLD) begin
      // Float first, grant one cycle later, release before driving
      if (t_r == cbl_pkg::T_ADDR) begin
        t_nxt = cbl_pkg::T_STRB;
      end else if (t_r == cbl_pkg::T_STRB) begin
        if (!hold) t_nxt = cbl_pkg::T_REFRESH_STROBE_N;
      end else begin
        mc_nxt = res_r;
        t_nxt = cbl_pkg::T_ADDR;
      end
    end else if (!stall) begin
      if (t_r == cbl_pkg::T_STRB) din_nxt = i_data;
      if (mc_r == cbl_pkg::MC_FETCH && t_r == cbl_pkg::T_REFRESH_STROBE_N) begin
        rr_nxt = {rr_r[7], rr_r[6:0] + 7'h01};
      end
      if (t_r != mc_len(mc_r, ilen_r)) begin
        t_nxt = t_r + 3'h1;
      end else begin
        t_nxt = cbl_pkg::T_ADDR;
        if ((mc_r == cbl_pkg::MC_FETCH && !halt_r) ||
            (mc_r == cbl_pkg::MC_READ && ph_r != cbl_pkg::PH_RD)) begin
          pc_nxt = pc_r + 16'h0001;
        end
        case (ph_r)
          cbl_pkg::PH_OP: begin
            op_nxt = din_r;
            nmc = cbl_pkg::MC_READ;
            ma_nxt = hl;
            if (halt_r) begin
              fin = 1'b1;
            end else if (ed_r) begin
              nmc = cbl_pkg::MC_IDLE;
              nph = cbl_pkg::PH_EDX;
              ilen_nxt = cbl_pkg::ED_IDLE;
            end else if (o == cbl_pkg::OP_PFX_X) begin
              pfx_nxt = 2'h1;
              nmc = cbl_pkg::MC_FETCH;
            end else if (o == cbl_pkg::OP_PFX_Y) begin
              pfx_nxt = 2'h2;
              nmc = cbl_pkg::MC_FETCH;
            end else if (o == cbl_pkg::OP_PFX_E) begin
              ed_nxt = 1'b1;
              nmc = cbl_pkg::MC_FETCH;
            end else if (o == cbl_pkg::OP_HALT) begin
              halt_nxt = 1'b1;
              fin = 1'b1;
            end else if (o[7:6] == 2'b01 && o[2:0] == cbl_pkg::REG_M) begin
              nph = (pfx_r != 2'h0) ? cbl_pkg::PH_DISP : cbl_pkg::PH_RD;
            end else if (o[7:6] == 2'b01 && o[5:3] == cbl_pkg::REG_M) begin
              wd_nxt = rf_r[o[2:0]];
              if (pfx_r != 2'h0) begin
                nph = cbl_pkg::PH_DISP;
              end else begin
                nmc = cbl_pkg::MC_WRITE;
                nph = cbl_pkg::PH_WR;
              end
            end else if (o[7:6] == 2'b01) begin
              rf_nxt[o[5:3]] = rf_r[o[2:0]];
              fin = 1'b1;
            end else if (o == cbl_pkg::OP_LD_MI) begin
              nph = (pfx_r != 2'h0) ? cbl_pkg::PH_DISP : cbl_pkg::PH_IMM;
            end else if (o[7:6] == 2'b00 && o[2:0] == 3'h6) begin
              nph = cbl_pkg::PH_IMM;
            end else if (o == cbl_pkg::OP_LDA_BC ||
                         o == cbl_pkg::OP_STA_BC) begin
              ma_nxt = pair(rf_r[0], rf_r[1]);
              wd_nxt = rf_r[cbl_pkg::REG_A];
              nph = o[3] ? cbl_pkg::PH_RD : cbl_pkg::PH_WR;
              nmc = o[3] ? cbl_pkg::MC_READ : cbl_pkg::MC_WRITE;
            end else if (o == cbl_pkg::OP_LDA_DE ||
                         o == cbl_pkg::OP_STA_DE) begin
              ma_nxt = pair(rf_r[2], rf_r[3]);
              wd_nxt = rf_r[cbl_pkg::REG_A];
              nph = o[3] ? cbl_pkg::PH_RD : cbl_pkg::PH_WR;
              nmc = o[3] ? cbl_pkg::MC_READ : cbl_pkg::MC_WRITE;
            end else if (o == cbl_pkg::OP_LDA_NN ||
                         o == cbl_pkg::OP_STA_NN) begin
              nph = cbl_pkg::PH_LO;
            end else if (o == cbl_pkg::OP_DI || o == cbl_pkg::OP_EI) begin
              iff_nxt = o[3];
              fin = 1'b1;
            end else begin
              fin = 1'b1;
            end
          end
          cbl_pkg::PH_DISP: begin
            disp_nxt = din_r;
            if (op_r == cbl_pkg::OP_LD_MI) begin
              nmc = cbl_pkg::MC_READ;
              nph = cbl_pkg::PH_IMM;
            end else begin
              nmc = cbl_pkg::MC_IDLE;
              nph = cbl_pkg::PH_XI;
              ilen_nxt = cbl_pkg::IDX_IDLE;
              aft_nxt = (op_r[5:3] == cbl_pkg::REG_M) ? cbl_pkg::PH_WR :
                        cbl_pkg::PH_RD;
            end
          end
          cbl_pkg::PH_IMM: begin
            if (op_r == cbl_pkg::OP_LD_MI) begin
              wd_nxt = din_r;
              nmc = cbl_pkg::MC_WRITE;
              nph = cbl_pkg::PH_WR;
              if (pfx_r != 2'h0) begin
                nmc = cbl_pkg::MC_IDLE;
                nph = cbl_pkg::PH_XI;
                ilen_nxt = cbl_pkg::IMM_IDLE;
                aft_nxt = cbl_pkg::PH_WR;
              end
            end else begin
              rf_nxt[op_r[5:3]] = din_r;
              fin = 1'b1;
            end
          end
          cbl_pkg::PH_LO: begin
            lo_nxt = din_r;
            nmc = cbl_pkg::MC_READ;
            nph = cbl_pkg::PH_HI;
          end
          cbl_pkg::PH_HI: begin
            ma_nxt = pair(din_r, lo_r);
            nmc = cbl_pkg::MC_READ;
            nph = cbl_pkg::PH_RD;
            if (op_r == cbl_pkg::OP_STA_NN) begin
              nmc = cbl_pkg::MC_WRITE;
              nph = cbl_pkg::PH_WR;
              wd_nxt = rf_r[cbl_pkg::REG_A];
            end
          end
          cbl_pkg::PH_XI: begin
            ma_nxt = ea(pfx_r, hl, ix_r, iy_r, disp_r);
            nph = aft_r;
            nmc = (aft_r == cbl_pkg::PH_WR) ? cbl_pkg::MC_WRITE :
                  cbl_pkg::MC_READ;
          end
          cbl_pkg::PH_RD: begin
            rf_nxt[(op_r[7:6] == 2'b00) ? cbl_pkg::REG_A : op_r[5:3]] =
              din_r;
            fin = 1'b1;
          end
          cbl_pkg::PH_EDX: begin
            src = (op_r == cbl_pkg::ED_A_R) ? rr_r : i_r;
            if (op_r == cbl_pkg::ED_A_I || op_r == cbl_pkg::ED_A_R) begin
              rf_nxt[cbl_pkg::REG_A] = src;
              rf_nxt[cbl_pkg::REG_F][cbl_pkg::FLG_S] = src[7];
              rf_nxt[cbl_pkg::REG_F][cbl_pkg::FLG_Z] = (src == 8'h00);
              rf_nxt[cbl_pkg::REG_F][cbl_pkg::FLG_H] = 1'b0;
              rf_nxt[cbl_pkg::REG_F][cbl_pkg::FLG_PV] = iff_r;
              rf_nxt[cbl_pkg::REG_F][cbl_pkg::FLG_N] = 1'b0;
            end else if (op_r == cbl_pkg::ED_I_A) begin
              i_nxt = rf_r[cbl_pkg::REG_A];
            end else if (op_r == cbl_pkg::ED_R_A) begin
              rr_nxt = rf_r[cbl_pkg::REG_A];
            end else if (op_r == cbl_pkg::ED_IM0) begin
              im_nxt = cbl_pkg::IM_0;
            end else if (op_r == cbl_pkg::ED_IM1) begin
              im_nxt = cbl_pkg::IM_1;
            end else if (op_r == cbl_pkg::ED_IM2) begin
              im_nxt = cbl_pkg::IM_2;
            end
            fin = 1'b1;
          end
          cbl_pkg::PH_INTA: begin
            pc_nxt = (im_r == cbl_pkg::IM_1) ? cbl_pkg::IM1_ADDR :
                     {8'h00, din_r & cbl_pkg::RST_MASK};
            fin = 1'b1;
          end
          default: begin
            fin = 1'b1;
          end
        endcase
        if (fin) begin
          nmc = cbl_pkg::MC_FETCH;
          nph = cbl_pkg::PH_OP;
          pfx_nxt = 2'h0;
          ed_nxt = 1'b0;
          if (npend_r) begin
            npend_nxt = 1'b0;
            iff_nxt = 1'b0;
            halt_nxt = 1'b0;
            pc_nxt = cbl_pkg::NMI_ADDR;
          end else if (iff_r && !flt_r[cbl_pkg::SY_INT]) begin
            iff_nxt = 1'b0;
            halt_nxt = 1'b0;
            nmc = cbl_pkg::MC_INTA;
            nph = cbl_pkg::PH_INTA;
          end
        end
        ph_nxt = nph;
        res_nxt = nmc;
        mc_nxt = hold ? cbl_pkg::MC_HOLD : nmc;
      end
    end
    if (nold_r && !flt_r[cbl_pkg::SY_NMI]) npend_nxt = 1'b1;
    // Pin image of the coming T state
    pins_nxt = cbl_pkg::PINS_RST;
    pins_nxt.addr_oe_n = 1'b0;
    pins_nxt.ctl_oe_n = 1'b0;
    pins_nxt.dout = wd_nxt;
    pins_nxt.halt_n = !halt_nxt;
    pins_nxt.addr = ma_nxt;
    case (mc_nxt)
      cbl_pkg::MC_FETCH, cbl_pkg::MC_INTA: begin
        pins_nxt.addr = pc_nxt;
        pins_nxt.fetch_cycle_n = !(t_nxt <= cbl_pkg::T_STRB);
        if (mc_nxt == cbl_pkg::MC_INTA) begin
          pins_nxt.fetch_cycle_n = 1'b0;
          pins_nxt.port_cycle_n = !(t_nxt == cbl_pkg::T_STRB);
        end else begin
          pins_nxt.memory_cycle_n = !(t_nxt == cbl_pkg::T_STRB ||
                                      t_nxt == cbl_pkg::T_REFRESH_STROBE_N);
          pins_nxt.rd_n = !(t_nxt == cbl_pkg::T_STRB);
          pins_nxt.refresh_strobe_n = !(t_nxt >= cbl_pkg::T_REFRESH_STROBE_N);
          if (t_nxt >= cbl_pkg::T_REFRESH_STROBE_N) pins_nxt.addr = pair(i_nxt, rr_nxt);
        end
      end
      cbl_pkg::MC_READ: begin
        if (ph_nxt != cbl_pkg::PH_RD) pins_nxt.addr = pc_nxt;
        pins_nxt.memory_cycle_n = !(t_nxt >= cbl_pkg::T_STRB);
        pins_nxt.rd_n = !(t_nxt >= cbl_pkg::T_STRB);
      end
      cbl_pkg::MC_WRITE: begin
        pins_nxt.data_oe_n = 1'b0;
        pins_nxt.memory_cycle_n = !(t_nxt == cbl_pkg::T_STRB);
        pins_nxt.wr_n = !(t_nxt == cbl_pkg::T_STRB);
      end
      cbl_pkg::MC_HOLD: begin
        pins_nxt.addr_oe_n = 1'b1;
        pins_nxt.ctl_oe_n = 1'b1;
        pins_nxt.bus_grant_n = !(t_nxt == cbl_pkg::T_STRB);
      end
      default: begin
        pins_nxt.addr = ma_nxt;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mc_r <= cbl_pkg::MC_HOLD;
      res_r <= cbl_pkg::MC_FETCH;
      ph_r <= cbl_pkg::PH_OP;
      aft_r <= cbl_pkg::PH_RD;
      t_r <= cbl_pkg::T_REFRESH_STROBE_N;
      ilen_r <= cbl_pkg::ED_IDLE;
      pfx_r <= 2'h0;
      im_r <= cbl_pkg::IM_0;
      ed_r <= 1'b0;
      iff_r <= 1'b0;
      halt_r <= 1'b0;
      npend_r <= 1'b0;
      nold_r <= 1'b1;
      op_r <= cbl_pkg::BYTE_RST;
      disp_r <= cbl_pkg::BYTE_RST;
      lo_r <= cbl_pkg::BYTE_RST;
      din_r <= cbl_pkg::BYTE_RST;
      wd_r <= cbl_pkg::BYTE_RST;
      i_r <= cbl_pkg::BYTE_RST;
      rr_r <= cbl_pkg::BYTE_RST;
      ma_r <= cbl_pkg::WORD_RST;
      pc_r <= cbl_pkg::WORD_RST;
      ix_r <= cbl_pkg::WORD_RST;
      iy_r <= cbl_pkg::WORD_RST;
      pins_r <= cbl_pkg::PINS_RST;
      for (int k = 0; k < 8; k++) begin
        rf_r[k] <= cbl_pkg::BYTE_RST;
      end
    end else begin
      mc_r <= mc_nxt;
      res_r <= res_nxt;
      ph_r <= ph_nxt;
      aft_r <= aft_nxt;
      t_r <= t_nxt;
      ilen_r <= ilen_nxt;
      pfx_r <= pfx_nxt;
      im_r <= im_nxt;
      ed_r <= ed_nxt;
      iff_r <= iff_nxt;
      halt_r <= halt_nxt;
      npend_r <= npend_nxt;
      nold_r <= nold_nxt;
      op_r <= op_nxt;
      disp_r <= disp_nxt;
      lo_r <= lo_nxt;
      din_r <= din_nxt;
      wd_r <= wd_nxt;
      i_r <= i_nxt;
      rr_r <= rr_nxt;
      ma_r <= ma_nxt;
      pc_r <= pc_nxt;
      pins_r <= pins_nxt;
      for (int k = 0; k < 8; k++) begin
        rf_r[k] <= rf_nxt[k];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_addr = pins_r.addr;
  assign o_addr_oe_n = pins_r.addr_oe_n;
  assign o_data = pins_r.dout;
  assign o_data_oe_n = pins_r.data_oe_n;
  assign o_ctl_oe_n = pins_r.ctl_oe_n;
  assign o_memory_cycle_n = pins_r.memory_cycle_n;
  assign o_port_cycle_n = pins_r.port_cycle_n;
  assign o_rd_n = pins_r.rd_n;
  assign o_wr_n = pins_r.wr_n;
  assign o_fetch_cycle_n = pins_r.fetch_cycle_n;
  assign o_refresh_strobe_n = pins_r.refresh_strobe_n;
  assign o_halt_n = pins_r.halt_n;
  assign o_bus_grant_n = pins_r.bus_grant_n;
endmodule

//--- tb/cbl_core_asserts.sv
`timescale 1ns/1ps
module cbl_core_asserts (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_nmi_n,
  input wire logic i_bus_hold_request_n,
  input wire logic [15:0] o_addr,
  input wire logic o_addr_oe_n,
  input wire logic o_data_oe_n,
  input wire logic o_ctl_oe_n,
  input wire logic o_memory_cycle_n,
  input wire logic o_port_cycle_n,
  input wire logic o_wr_n,
  input wire logic o_fetch_cycle_n,
  input wire logic o_refresh_strobe_n,
  input wire logic o_bus_grant_n
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  grant_float_a: assert property (
    !o_bus_grant_n |-> o_addr_oe_n && o_ctl_oe_n && o_data_oe_n)
    else $error("grant while bus driven");
  hold_grant_a: assert property (
    $fell(i_bus_hold_request_n) |-> ##[1:16] !o_bus_grant_n)
    else $error("hold not granted");
  fetch_strobe_a: assert property (
    $fell(o_fetch_cycle_n) |=> !o_memory_cycle_n || !o_port_cycle_n)
    else $error("fetch without strobe");
  store_data_a: assert property (
    !o_wr_n |-> !o_data_oe_n && !o_memory_cycle_n)
    else $error("store strobe without data");
  refresh_mem_a: assert property (
    $fell(o_refresh_strobe_n) |-> !o_memory_cycle_n)
    else $error("refresh without memory strobe");
  mem_addr_a: assert property (
    !o_memory_cycle_n |-> !o_addr_oe_n)
    else $error("memory strobe without address");
  nmi_restart_a: assert property (
    $fell(i_nmi_n) |-> ##[1:60] (!o_fetch_cycle_n && o_addr == 16'h0066))
    else $error("no restart at 0066");
  reset_idle_a: assert property (disable iff (1'b0)
    i_rst |-> o_addr_oe_n && o_ctl_oe_n && o_bus_grant_n)
    else $error("outputs active in reset");
endmodule
bind cbl_core cbl_core_asserts u_chk (.i_core_clk(i_core_clk),
  .i_rst(i_rst), .i_nmi_n(i_nmi_n),
  .i_bus_hold_request_n(i_bus_hold_request_n), .o_addr(o_addr),
  .o_addr_oe_n(o_addr_oe_n), .o_data_oe_n(o_data_oe_n),
  .o_ctl_oe_n(o_ctl_oe_n), .o_memory_cycle_n(o_memory_cycle_n),
  .o_port_cycle_n(o_port_cycle_n), .o_wr_n(o_wr_n),
  .o_fetch_cycle_n(o_fetch_cycle_n),
  .o_refresh_strobe_n(o_refresh_strobe_n), .o_bus_grant_n(o_bus_grant_n));

//--- tb/cbl_mem_model.sv
`timescale 1ns/1ps
module cbl_mem_model (
  input wire logic i_clk,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_memory_cycle_n,
  input wire logic i_port_cycle_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_fetch_cycle_n,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last_r = 8'h00;
  always_comb begin
    if (!i_rd_n && !i_memory_cycle_n) begin
      o_rdata = mem[i_addr[7:0]];
    end else if (!i_port_cycle_n && !i_fetch_cycle_n) begin
      o_rdata = 8'hff;
    end else begin
      o_rdata = ~last_r;
    end
  end
  always @(posedge i_clk) begin
    last_r <= o_rdata;
    if (!i_wr_n && !i_memory_cycle_n) mem[i_addr[7:0]] <= i_wdata;
  end
endmodule

//--- tb/test_cpu_bus_control_and_byte_loads.sv
`timescale 1ns/1ps
module test_cpu_bus_control_and_byte_loads;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b0;
  logic i_wait_n = 1'b1;
  logic i_int_n = 1'b1;
  logic i_nmi_n = 1'b1;
  logic i_bus_hold_request_n = 1'b1;
  logic [7:0] i_data, o_data;
  logic [15:0] o_addr;
  logic o_addr_oe_n, o_data_oe_n, o_ctl_oe_n, o_memory_cycle_n;
  logic o_port_cycle_n, o_rd_n, o_wr_n, o_fetch_cycle_n;
  logic o_refresh_strobe_n, o_halt_n, o_bus_grant_n;
  int mismatches = 0;
  int checks = 0;
  int n;
  logic [7:0] prog [27] = '{8'h3a, 8'h40, 8'h00, 8'h32, 8'h41, 8'h00,
    8'h36, 8'ha5, 8'h7e, 8'h32, 8'h42, 8'h00, 8'hed, 8'h47, 8'h3a, 8'h40,
    8'h00, 8'hed, 8'h57, 8'h32, 8'h43, 8'h00, 8'hdd, 8'h36, 8'h44, 8'h3c,
    8'h76};
  always #20 i_core_clk = ~i_core_clk;
  cbl_core u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_data(i_data),
    .i_wait_n(i_wait_n), .i_int_n(i_int_n), .i_nmi_n(i_nmi_n),
    .i_bus_hold_request_n(i_bus_hold_request_n), .o_addr(o_addr),
    .o_addr_oe_n(o_addr_oe_n), .o_data(o_data), .o_data_oe_n(o_data_oe_n),
    .o_ctl_oe_n(o_ctl_oe_n), .o_memory_cycle_n(o_memory_cycle_n),
    .o_port_cycle_n(o_port_cycle_n), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n),
    .o_fetch_cycle_n(o_fetch_cycle_n), .o_halt_n(o_halt_n),
    .o_refresh_strobe_n(o_refresh_strobe_n), .o_bus_grant_n(o_bus_grant_n));
  cbl_mem_model u_mem (.i_clk(i_core_clk), .i_addr(o_addr),
    .i_wdata(o_data), .i_memory_cycle_n(o_memory_cycle_n),
    .i_port_cycle_n(o_port_cycle_n), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n),
    .i_fetch_cycle_n(o_fetch_cycle_n), .o_rdata(i_data));
  task chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      $display("[FAIL] %0t %s", $time, msg);
      mismatches++;
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task t_reset();
    repeat (10) @(posedge i_core_clk);
    chk(o_addr_oe_n === 1'b1 && o_ctl_oe_n === 1'b1, "bus driven");
    chk(o_bus_grant_n === 1'b1 && o_halt_n === 1'b1, "ctl active");
    i_rst <= 1'b0;
    for (n = 0; n < 8 && o_fetch_cycle_n !== 1'b0; n++) @(posedge i_core_clk);
    chk(o_addr === 16'h0000, "first fetch address");
    $display("reset test done");
  endtask
  task t_loads();
    i_wait_n <= 1'b0;
    repeat (6) @(posedge i_core_clk);
    i_wait_n <= 1'b1;
    for (n = 0; n < 300 && o_halt_n !== 1'b0; n++) @(posedge i_core_clk);
    chk(u_mem.mem[8'h41] === 8'h5a, "absolute copy");
    chk(u_mem.mem[8'h00] === 8'ha5, "immediate store");
    chk(u_mem.mem[8'h42] === 8'ha5, "pointer load");
    chk(u_mem.mem[8'h43] === 8'ha5, "vector base copy");
    chk(u_mem.mem[8'h44] === 8'h3c, "indexed store");
    chk(o_halt_n === 1'b0, "no halt");
    $display("load test done");
  endtask
  task t_int();
    i_int_n <= 1'b0;
    repeat (40) @(posedge i_core_clk);
    chk(o_halt_n === 1'b0, "masked int taken");
    i_int_n <= 1'b1;
    $display("int test done");
  endtask
  task t_nmi();
    i_nmi_n <= 1'b0;
    repeat (6) @(posedge i_core_clk);
    i_nmi_n <= 1'b1;
    for (n = 0; n < 80 && !(o_fetch_cycle_n === 1'b0 &&
         o_addr === 16'h0066); n++) @(posedge i_core_clk);
    chk(o_addr === 16'h0066 && o_fetch_cycle_n === 1'b0, "nmi");
    $display("nmi test done");
  endtask
  task t_ack();
    i_int_n <= 1'b0;
    for (n = 0; n < 60 && !(o_port_cycle_n === 1'b0 &&
         o_fetch_cycle_n === 1'b0); n++) @(posedge i_core_clk);
    chk(o_port_cycle_n === 1'b0 && o_halt_n === 1'b1, "ack");
    for (n = 0; n < 20 && !(o_fetch_cycle_n === 1'b0 &&
         o_addr === 16'h0038); n++) @(posedge i_core_clk);
    chk(o_addr === 16'h0038 && o_fetch_cycle_n === 1'b0, "vector");
    i_int_n <= 1'b1;
    $display("ack test done");
  endtask
  task t_hold();
    i_bus_hold_request_n <= 1'b0;
    for (n = 0; n < 30 && o_bus_grant_n !== 1'b0; n++) @(posedge i_core_clk);
    chk(o_bus_grant_n === 1'b0 && o_addr_oe_n === 1'b1, "grant");
    i_bus_hold_request_n <= 1'b1;
    for (n = 0; n < 30 && o_bus_grant_n !== 1'b1; n++) @(posedge i_core_clk);
    chk(o_bus_grant_n === 1'b1, "grant not dropped");
    $display("hold test done");
  endtask
  initial begin
    i_rst <= 1'b1;
    for (n = 0; n < 256; n++) u_mem.mem[n] = 8'h00;
    for (n = 0; n < 27; n++) u_mem.mem[n] = prog[n];
    u_mem.mem[8'h40] = 8'h5a;
    u_mem.mem[8'h66] = 8'hfb;
    u_mem.mem[8'h67] = 8'h76;
    u_mem.mem[8'h38] = 8'h76;
    t_reset();
    t_loads();
    t_int();
    t_nmi();
    t_ack();
    t_hold();
    results();
  end
  initial begin
    repeat (3000) @(posedge i_core_clk);
    mismatches++;
    results();
  end
endmodule
